// file: rtl/ired_endec.sv
// Infrared pulse encoder/decoder between a UART and an optical transceiver.
// Assumes baud_tick is one clock wide per baud-rate clock period and that
// the UART offers its transmit bits as a valid/ready stream.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module ired_endec
    import ired_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic baud_tick,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic uart_tx_valid,
    input wire logic uart_tx_bit,
    output logic uart_tx_ready,
    output logic uart_rxd,
    output logic optical_tx_out,
    input wire logic optical_rx_in
);
    logic [7:0] infrared_control;
    logic endec_enable;
    logic rx_decode_enable;
    logic loopback;
    logic rx_active;

    ired_enc_state_t state;
    ired_enc_state_t next_state;
    logic [3:0] pos;
    logic [3:0] next_pos;
    logic cur_bit;
    logic next_bit;
    logic pop;

    logic fifo_valid;
    logic fifo_bit;
    logic fifo_full;
    logic fifo_empty;

    logic dec_line;
    logic dec_bit;
    logic [1:0] high_ticks;

    function automatic logic at_pos(input logic [3:0] p, input logic [4:0] mark);
        at_pos = ({1'b0, p} == mark - 5'h01);
    endfunction

    assign endec_enable = infrared_control[ENDEC_ENABLE_BIT];
    assign rx_decode_enable = infrared_control[RX_DECODE_ENABLE_BIT];
    assign loopback = infrared_control[LOOPBACK_BIT];
    assign rx_active = endec_enable && rx_decode_enable;
    assign fifo_empty = !fifo_valid;

    // Control register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            infrared_control <= INFRARED_CONTROL_RESET;
        end else if (reg_write && reg_addr == INFRARED_CONTROL_OFFSET) begin
            // Reserved bits are dropped here, so they always read back zero
            infrared_control <= reg_wdata & INFRARED_CONTROL_MASK;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_read && reg_addr == INFRARED_CONTROL_OFFSET) begin
            reg_rdata <= infrared_control;
        end else if (reg_read && reg_addr == INFRARED_STATUS_OFFSET) begin
            reg_rdata <= {4'h0, fifo_empty, fifo_full, uart_rxd, (state != ENC_IDLE)};
        end else begin
            reg_rdata <= '0;
        end
    end

    // Transmit bit buffer; a stalled encoder backs up into the UART
    ired_fifo2 u_tx_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .in_valid(uart_tx_valid),
        .in_data(uart_tx_bit),
        .in_ready(uart_tx_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_bit),
        .out_ready(pop),
        .full(fifo_full)
    );

    // Encoder sequencing; bits are taken back to back with no idle gap
    always_comb begin
        next_state = state;
        next_pos = pos;
        next_bit = cur_bit;
        pop = 1'b0;
        if (!endec_enable) begin
            next_state = ENC_IDLE;
            next_pos = 4'h0;
        end else if (baud_tick) begin
            case (state)
                ENC_IDLE: begin
                    if (fifo_valid) begin
                        pop = 1'b1;
                        next_bit = fifo_bit;
                        next_pos = 4'h0;
                        next_state = ENC_LEAD;
                    end
                end
                ENC_LEAD: begin
                    next_pos = pos + 4'h1;
                    if (at_pos(pos, LEAD_TICKS)) next_state = ENC_PULSE;
                end
                ENC_PULSE: begin
                    next_pos = pos + 4'h1;
                    if (at_pos(pos, LEAD_TICKS + PULSE_TICKS)) next_state = ENC_TAIL;
                end
                ENC_TAIL: begin
                    next_pos = pos + 4'h1;
                    if (at_pos(pos, LEAD_TICKS + PULSE_TICKS + TAIL_TICKS)) begin
                        // Sixteenth tick closes the bit
                        next_pos = 4'h0;
                        if (fifo_valid) begin
                            pop = 1'b1;
                            next_bit = fifo_bit;
                            next_state = ENC_LEAD;
                        end else begin
                            next_state = ENC_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = ENC_IDLE;
                    next_pos = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ENC_IDLE;
            pos <= 4'h0;
            cur_bit <= 1'b1;
        end else begin
            state <= next_state;
            pos <= next_pos;
            cur_bit <= next_bit;
        end
    end

    // Only a zero raises the output, and only in the pulse slot
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            optical_tx_out <= 1'b0;
        end else begin
            optical_tx_out <= endec_enable && (next_state == ENC_PULSE) && !next_bit;
        end
    end

    // Decoder input: inverted transmit in loopback, else the pin
    assign dec_line = loopback ? !optical_tx_out : optical_rx_in;

    ired_decoder u_decoder (
        .clock(clock),
        .rst_b(rst_b),
        .baud_tick(baud_tick),
        .clear(!rx_active),
        .line(dec_line),
        .bit_out(dec_bit)
    );

    // Transmit activity does not block decoding; the encoder enable and receive enable together gate it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            uart_rxd <= 1'b1;
        end else begin
            uart_rxd <= rx_active ? dec_bit : 1'b1;
        end
    end

    // Helper: ticks the output has been high
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            high_ticks <= 2'h0;
        end else if (!optical_tx_out) begin
            high_ticks <= 2'h0;
        end else if (baud_tick && high_ticks != 2'h3) begin
            high_ticks <= high_ticks + 2'h1;
        end
    end

    property p_one_low;
        @(posedge clock) disable iff (!rst_b)
        (state != ENC_IDLE && cur_bit) |-> !optical_tx_out;
    endproperty
    a_one_low: assert property (p_one_low)
        else $error("one bit produced a pulse");

    property p_pulse_start;
        @(posedge clock) disable iff (!rst_b)
        $rose(optical_tx_out) |-> (pos == 4'h7 && !cur_bit && state == ENC_PULSE);
    endproperty
    a_pulse_start: assert property (p_pulse_start)
        else $error("pulse did not start after seven low ticks");

    property p_pulse_width;
        @(posedge clock) disable iff (!rst_b)
        ($fell(optical_tx_out) && $past(endec_enable)) |-> high_ticks == 2'h3 &&
            $past(high_ticks) == 2'h2 && pos == 4'hA;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("pulse not three ticks wide");

    property p_bit_wrap;
        @(posedge clock) disable iff (!rst_b)
        (baud_tick && endec_enable && state == ENC_TAIL && pos == 4'hF) |=>
            (pos == 4'h0 && (state == ENC_LEAD || state == ENC_IDLE));
    endproperty
    a_bit_wrap: assert property (p_bit_wrap)
        else $error("bit period not sixteen ticks");

    property p_disabled_quiet;
        @(posedge clock) disable iff (!rst_b)
        !endec_enable |=> (!optical_tx_out && uart_rxd && state == ENC_IDLE);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled block not idle");

    property p_rx_ignored;
        @(posedge clock) disable iff (!rst_b)
        (endec_enable && !rx_decode_enable) |=> uart_rxd;
    endproperty
    a_rx_ignored: assert property (p_rx_ignored)
        else $error("receive data passed while disabled");

    property p_rx_passed;
        @(posedge clock) disable iff (!rst_b)
        rx_active |=> (uart_rxd == $past(dec_bit));
    endproperty
    a_rx_passed: assert property (p_rx_passed)
        else $error("decoded data not passed to UART");

    property p_enable_bit;
        @(posedge clock) disable iff (!rst_b)
        (reg_write && reg_addr == INFRARED_CONTROL_OFFSET) |=>
            (endec_enable == $past(reg_wdata[0]) && infrared_control[7:3] == 5'h00);
    endproperty
    a_enable_bit: assert property (p_enable_bit)
        else $error("control write not taken");

    property p_reserved_read;
        @(posedge clock) disable iff (!rst_b)
        (reg_read && reg_addr == INFRARED_CONTROL_OFFSET) |=> reg_rdata[7:3] == 5'h00;
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("reserved bits read nonzero");

    property p_loop_source;
        @(posedge clock) disable iff (!rst_b)
        (rx_active && loopback && optical_tx_out) |-> !dec_line;
    endproperty
    a_loop_source: assert property (p_loop_source)
        else $error("loopback not inverted");

    c_zero_sent: cover property (@(posedge clock) disable iff (!rst_b) $fell(optical_tx_out));
    c_zero_decoded: cover property (@(posedge clock) disable iff (!rst_b) $fell(uart_rxd));
    c_fifo_full: cover property (@(posedge clock) disable iff (!rst_b) fifo_full && !pop);
    c_loop_zero: cover property (@(posedge clock) disable iff (!rst_b)
        loopback && rx_active && $fell(uart_rxd));
endmodule

// file: inc/ired_pkg.sv
// Shared constants of the infrared pulse encoder/decoder.
// Assumes one system clock; the baud-rate clock arrives as a one-cycle tick.
package ired_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FIFO_W = 1;
    localparam int FIFO_DEPTH = 2;

    // Register map
    localparam logic [7:0] INFRARED_CONTROL_OFFSET = 8'hBF;
    localparam logic [7:0] INFRARED_STATUS_OFFSET = 8'hBE;
    localparam logic [7:0] INFRARED_CONTROL_RESET = 8'h00;
    localparam logic [7:0] INFRARED_CONTROL_MASK = 8'h07;

    // Control fields
    localparam int ENDEC_ENABLE_BIT = 0;
    localparam int RX_DECODE_ENABLE_BIT = 1;
    localparam int LOOPBACK_BIT = 2;

    // Status fields
    localparam int STAT_TX_BUSY_BIT = 0;
    localparam int STAT_RX_LEVEL_BIT = 1;
    localparam int STAT_FIFO_FULL_BIT = 2;
    localparam int STAT_FIFO_EMPTY_BIT = 3;

    // Bit timing in baud-clock periods
    localparam logic [4:0] BIT_TICKS = 5'h10;
    localparam logic [4:0] LEAD_TICKS = 5'h07;
    localparam logic [4:0] PULSE_TICKS = 5'h03;
    localparam logic [4:0] TAIL_TICKS = 5'h06;

    typedef enum logic [1:0] {
        ENC_IDLE = 2'h0,
        ENC_LEAD = 2'h1,
        ENC_PULSE = 2'h3,
        ENC_TAIL = 2'h2
    } ired_enc_state_t;
endpackage

// file: rtl/ired_fifo2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock; the drain side may stall for any time.
`timescale 1ns/10ps
module ired_fifo2
    import ired_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [FIFO_W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [FIFO_W-1:0] out_data,
    input wire logic out_ready,
    output logic full
);
    logic [FIFO_W-1:0] slot [FIFO_DEPTH];
    logic rd_idx;
    logic wr_idx;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign full = (count == 2'h2);
    assign out_data = slot[rd_idx];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            slot[0] <= '0;
            slot[1] <= '0;
        end else if (push) begin
            slot[wr_idx] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_idx <= ~wr_idx;
            if (pop) rd_idx <= ~rd_idx;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // A third entry would mean a bit lost or sent twice
    property p_no_overflow;
        @(posedge clock) disable iff (!rst_b)
        count != 2'h3;
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("buffer count out of range");
endmodule

// file: rtl/ired_decoder.sv
// Pulse decoder: a falling edge on the sampled line yields a 16-tick zero.
// Assumes the line is already selected and synchronous to the clock.
`timescale 1ns/10ps
module ired_decoder
    import ired_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic baud_tick,
    input wire logic clear,
    input wire logic line,
    output logic bit_out
);
    logic sample_prev;
    logic [4:0] hold;
    logic fall;
    logic [7:0] low_ticks;

    // Sampled only on ticks, so the first bit's start may jitter by one tick
    assign fall = baud_tick && sample_prev && !line;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sample_prev <= 1'b1;
        end else if (clear) begin
            sample_prev <= 1'b1;
        end else if (baud_tick) begin
            sample_prev <= line;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hold <= 5'h00;
            bit_out <= 1'b1;
        end else if (clear) begin
            hold <= 5'h00;
            bit_out <= 1'b1;
        end else if (fall) begin
            hold <= BIT_TICKS;
            bit_out <= 1'b0;
        end else if (baud_tick && hold != 5'h00) begin
            hold <= hold - 5'h01;
            if (hold == 5'h01) bit_out <= 1'b1;
        end
    end

    // Helper: ticks spent low
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            low_ticks <= 8'h00;
        end else if (bit_out) begin
            low_ticks <= 8'h00;
        end else if (baud_tick) begin
            low_ticks <= low_ticks + 8'h01;
        end
    end

    property p_zero_width;
        @(posedge clock) disable iff (!rst_b)
        ($rose(bit_out) && !$past(clear)) |-> (low_ticks[3:0] == 4'h0 && low_ticks != 8'h00);
    endproperty
    a_zero_width: assert property (p_zero_width)
        else $error("decoded zero not a multiple of sixteen ticks");

    property p_one_holds;
        @(posedge clock) disable iff (!rst_b)
        (bit_out && !fall) |=> bit_out;
    endproperty
    a_one_holds: assert property (p_one_holds)
        else $error("decoded one dropped without a pulse");
endmodule

// file: sim/ired_optic_model.sv
// Behavioural optical transceiver facing the encoder/decoder.
// Assumes baud_tick is the same one-clock pulse that the device sees.
`timescale 1ns/10ps
module ired_optic_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic baud_tick,
    input wire logic optical_tx_out,
    input wire logic echo_enable,
    output logic optical_rx_in
);
    logic bits_q[$];
    logic cur;
    logic busy;
    logic [3:0] pos;

    task automatic send_bit(input logic b);
        bits_q.push_back(b);
    endtask

    // Bits go out back to back, sixteen ticks each
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            cur <= 1'b1;
            pos <= 4'h0;
        end else if (baud_tick) begin
            if (busy && pos != 4'hF) begin
                pos <= pos + 4'h1;
            end else if (bits_q.size() != 0) begin
                cur <= bits_q.pop_front();
                busy <= 1'b1;
                pos <= 4'h0;
            end else begin
                busy <= 1'b0;
            end
        end
    end

    // Idle high; a zero is a low pulse at ticks 7 to 9; echo mimics own light
    assign optical_rx_in = echo_enable ? ~optical_tx_out :
        ~(busy && !cur && pos >= 4'h7 && pos <= 4'h9);
endmodule

// file: sim/ired_endec_test.sv
// Self-checking bench for the infrared encoder/decoder.
// Assumes the optical model sits on the far side; baud tick every 4 clocks.
`timescale 1ns/10ps
module ired_endec_test
    import ired_pkg::*;
();
    logic clock, rst_b, reg_write, reg_read, echo_enable;
    logic baud_tick = 1'b0;
    logic uart_tx_valid, uart_tx_bit, uart_tx_ready, uart_rxd, optical_tx_out, optical_rx_in;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
    logic [1:0] baud_div = 2'h0;
    int mismatches, checks_done, cycles, tick_n, tx_run, rx_run;
    int txr[$], rxr[$], rises[$], falls[$];

    ired_endec ired_endec_i (.clock(clock), .rst_b(rst_b), .baud_tick(baud_tick),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .uart_tx_valid(uart_tx_valid),
        .uart_tx_bit(uart_tx_bit), .uart_tx_ready(uart_tx_ready), .uart_rxd(uart_rxd),
        .optical_tx_out(optical_tx_out), .optical_rx_in(optical_rx_in));
    // Pins wired straight through, UART live, modem lines absent
    ired_optic_model ired_optic_model_i (.clock(clock), .rst_b(rst_b),
        .baud_tick(baud_tick), .optical_tx_out(optical_tx_out),
        .echo_enable(echo_enable), .optical_rx_in(optical_rx_in));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        baud_div <= baud_div + 2'h1;
        baud_tick <= (baud_div == 2'h3);
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    // Run lengths in ticks of high transmit pulses and low decoded bits
    always @(posedge clock) begin
        if (baud_tick === 1'b1) begin
            tick_n++;
            if (optical_tx_out === 1'b1) begin
                if (tx_run == 0) rises.push_back(tick_n);
                tx_run++;
            end else if (tx_run != 0) begin
                txr.push_back(tx_run);
                tx_run = 0;
            end
            if (uart_rxd === 1'b0) begin
                if (rx_run == 0) falls.push_back(tick_n);
                rx_run++;
            end else if (rx_run != 0) begin
                rxr.push_back(rx_run);
                rx_run = 0;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Bounded wait on ready; a stuck buffer gives up after 2000 cycles and drops valid
    task automatic tx_bit(input logic b);
        int n;
        n = 0;
        @(posedge clock);
        uart_tx_valid <= 1'b1;
        uart_tx_bit <= b;
        @(negedge clock);
        while (uart_tx_ready !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        uart_tx_valid <= 1'b0;
    endtask

    task automatic wait_ticks(input int n);
        repeat (n * 4) @(posedge clock);
    endtask

    task automatic clear_mon();
        txr.delete();
        rxr.delete();
        rises.delete();
        falls.delete();
    endtask

    initial begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        uart_tx_valid = 1'b0;
        uart_tx_bit = 1'b0;
        echo_enable = 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        check(uart_rxd, 1'b1);
        check(optical_tx_out, 1'b0);
        reg_rd(INFRARED_CONTROL_OFFSET, rd);
        check(rd, INFRARED_CONTROL_RESET);
        reg_rd(INFRARED_STATUS_OFFSET, rd);
        check(rd, 8'h0A);
        reg_wr(INFRARED_CONTROL_OFFSET, 8'hFF);
        reg_rd(INFRARED_CONTROL_OFFSET, rd);
        check(rd, 8'h07);
        reg_wr(8'h10, 8'h55);
        reg_rd(8'h10, rd);
        check(rd, 8'h00);
        reg_rd(INFRARED_CONTROL_OFFSET, rd);
        check(rd, 8'h07);
        // Disabled: buffer fills and refuses, nothing leaves or arrives
        reg_wr(INFRARED_CONTROL_OFFSET, 8'h00);
        clear_mon();
        tx_bit(1'b0);
        tx_bit(1'b1);
        @(negedge clock);
        check(uart_tx_ready, 1'b0);
        reg_rd(INFRARED_STATUS_OFFSET, rd);
        check(rd, 8'h06);
        ired_optic_model_i.send_bit(1'b0);
        wait_ticks(40);
        check(rises.size(), 0);
        check(falls.size(), 0);
        // Encoder drains 0,1 then 0,0 back to back
        reg_wr(INFRARED_CONTROL_OFFSET, 8'h01);
        tx_bit(1'b0);
        tx_bit(1'b0);
        wait_ticks(90);
        check(txr.size(), 3);
        foreach (txr[i]) check(txr[i], 3);
        check(rises[1] - rises[0], 32);
        check(rises[2] - rises[1], 16);
        // Receive enable clear ignores the line
        clear_mon();
        ired_optic_model_i.send_bit(1'b0);
        wait_ticks(24);
        check(falls.size(), 0);
        // Decoding 0,1,0,0 with the transmitter quiet
        reg_wr(INFRARED_CONTROL_OFFSET, 8'h03);
        clear_mon();
        ired_optic_model_i.send_bit(1'b0);
        ired_optic_model_i.send_bit(1'b1);
        ired_optic_model_i.send_bit(1'b0);
        ired_optic_model_i.send_bit(1'b0);
        wait_ticks(80);
        check(rxr.size(), 2);
        check(rxr[0], 16);
        check(rxr[1], 32);
        check(falls[1] - falls[0], 32);
        // Internal loopback: inverted pulse decodes one tick after it starts
        reg_wr(INFRARED_CONTROL_OFFSET, 8'h07);
        clear_mon();
        tx_bit(1'b0);
        wait_ticks(40);
        check(rxr.size(), 1);
        check(rxr[0], 16);
        check(falls[0] - rises[0], 1);
        // External loopback through the transceiver echo
        reg_wr(INFRARED_CONTROL_OFFSET, 8'h03);
        @(posedge clock);
        echo_enable <= 1'b1;
        clear_mon();
        tx_bit(1'b0);
        wait_ticks(40);
        check(txr[0], 3);
        check(rxr.size(), 1);
        check(falls[0] - rises[0], 1);
        // Mid-run reset returns control to zero and quiets the outputs
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        echo_enable <= 1'b0;
        @(negedge clock);
        check(uart_rxd, 1'b1);
        check(uart_tx_ready, 1'b1);
        reg_rd(INFRARED_CONTROL_OFFSET, rd);
        check(rd, INFRARED_CONTROL_RESET);
        complete_run();
    end
endmodule
